//--- hdl/awd_wdw_cfg.svh
`ifndef AWD_WDW_CFG_SVH
`define AWD_WDW_CFG_SVH
// Register word indices; byte address is four times the index
`define AWD_IDX_C2_HYS      8'h28
`define AWD_IDX_C2_HIGH     8'h29
`define AWD_IDX_C2_EVT      8'h2A
`define AWD_IDX_C2_LOW      8'h2B
`define AWD_IDX_C3_HYS      8'h2C
`define AWD_IDX_C3_HIGH     8'h2D
`define AWD_IDX_C3_EVT      8'h2E
`define AWD_IDX_C3_LOW      8'h2F
`define AWD_IDX_STATUS      8'h40
`define AWD_IDX_MASK        8'h41
`define AWD_IDX_SAMPLE      8'h42
// Reset values
`define AWD_RST_HYS         8'hF0
`define AWD_RST_HIGH        8'hFF
`define AWD_RST_EVT         8'h00
`define AWD_RST_LOW         8'h00
// Field positions
`define AWD_NIB_HI          7
`define AWD_NIB_LO          4
`define AWD_FLD_HI          3
`define AWD_FLD_LO          0
`define AWD_HYS_SHIFT       3
`define AWD_STAT_C2         0
`define AWD_STAT_C3         1
`endif

//--- hdl/awd_wdw_pkg.sv
package awd_wdw_pkg;
    typedef logic [11:0] awd_sample_t;
    typedef logic [7:0]  awd_byte_t;
    typedef enum logic [1:0] {AWD_IN_WINDOW, AWD_ABOVE, AWD_BELOW} awd_zone_t;
endpackage : awd_wdw_pkg

//--- hdl/awd_chan_if.sv
`timescale 1ns/1ps
interface awd_chan_if;
    logic [7:0]  hys_reg;
    logic [7:0]  high_reg;
    logic [7:0]  evt_reg;
    logic [7:0]  low_reg;
    logic        smp_vld;
    logic [11:0] smp;
    logic        alert;
    modport cfg (output hys_reg, high_reg, evt_reg, low_reg, smp_vld, smp, input alert);
    modport cmp (input hys_reg, high_reg, evt_reg, low_reg, smp_vld, smp, output alert);
endinterface : awd_chan_if

//--- hdl/awd_chan_cmp.sv
`timescale 1ns/1ps
`include "awd_wdw_cfg.svh"
module awd_chan_cmp
    import awd_wdw_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    awd_chan_if.cmp     ch
);
    // ------------------------------------------------------------
    // Limits and hysteresis
    // ------------------------------------------------------------
    wire awd_sample_t high_lim = {ch.high_reg, ch.hys_reg[`AWD_NIB_HI:`AWD_NIB_LO]};
    wire awd_sample_t low_lim  = {ch.low_reg, ch.evt_reg[`AWD_NIB_HI:`AWD_NIB_LO]};
    wire logic [6:0]  hys      = {ch.hys_reg[`AWD_FLD_HI:`AWD_FLD_LO], 3'h0};
    wire logic [3:0]  need_n   = ch.evt_reg[`AWD_FLD_HI:`AWD_FLD_LO];
    wire logic [12:0] high_rel = {1'b0, high_lim} - {6'h00, hys};
    wire logic [12:0] low_rel  = {1'b0, low_lim} + {6'h00, hys};
    wire logic        above    = ch.smp > high_lim;
    wire logic        below    = ch.smp < low_lim;
    wire logic        out_win  = above | below;

    logic        zone_out_ff;
    logic [4:0]  run_ff;
    logic        alert_ff;

    // Once out, stay out until sample recovers past the hysteresis band
    wire logic back_in = !high_rel[12] && ({1'b0, ch.smp} <= high_rel)
                         && ({1'b0, ch.smp} >= low_rel);
    wire logic exceed  = zone_out_ff ? !back_in : out_win;
    wire logic [4:0] nxt_run = exceed ? (run_ff == 5'h1F ? run_ff : run_ff + 5'h01) : 5'h00;

    // ------------------------------------------------------------
    // Consecutive-exceedance count
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zone_out_ff <= 1'b0;
            run_ff      <= 5'h00;
            alert_ff    <= 1'b0;
        end else if (ch.smp_vld) begin
            zone_out_ff <= exceed;
            run_ff      <= nxt_run;
            alert_ff    <= exceed && (nxt_run > {1'b0, need_n});
        end else begin
            alert_ff    <= 1'b0;
        end
    end
    assign ch.alert = alert_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_first_out;
        ch.smp_vld && out_win && !zone_out_ff && need_n == 4'h0;
    endsequence
    zero_count_alert_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_first_out |=> ch.alert) else $error("alert missing after one sample");
    inside_clears_run_a: assert property (@(posedge clk) disable iff (sys_rst)
        ch.smp_vld && !exceed |=> run_ff == 5'h00 && !ch.alert)
        else $error("run not restarted");
    alert_needs_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        ch.alert |-> $past(run_ff) >= {1'b0, $past(need_n)})
        else $error("alert too early");
    above_high_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        ch.smp_vld && ch.smp > high_lim |=> run_ff != 5'h00)
        else $error("above high limit not counted");
endmodule : awd_chan_cmp

//--- hdl/awd_wdw_top.sv
`timescale 1ns/1ps
`include "awd_wdw_cfg.svh"
module awd_wdw_top
    import awd_wdw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        smp_vld,
    input  wire logic [2:0]  smp_chan,
    input  wire logic [11:0] smp_data,
    output logic             irq
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    awd_byte_t cfg_ff [2][4];
    logic [1:0]  stat_ff;
    logic [1:0]  mask_ff;
    logic [11:0] last_ff;
    logic        irq_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic [9:0] idx      = paddr[11:2];
    wire logic       setup    = psel && !penable;
    wire logic       wr_do    = psel && penable && pready_ff && pwrite;
    wire logic       cfg_hit  = idx >= {2'h0, `AWD_IDX_C2_HYS} && idx <= {2'h0, `AWD_IDX_C3_LOW};
    wire logic [2:0] cfg_ofs  = 3'(idx - {2'h0, `AWD_IDX_C2_HYS});
    wire logic       cfg_ch   = cfg_ofs[2];
    wire logic [1:0] cfg_sel  = cfg_ofs[1:0];
    wire logic       st_hit   = idx == {2'h0, `AWD_IDX_STATUS};
    wire logic       mk_hit   = idx == {2'h0, `AWD_IDX_MASK};
    wire logic       sm_hit   = idx == {2'h0, `AWD_IDX_SAMPLE};
    wire logic       hit      = cfg_hit || st_hit || mk_hit || sm_hit;
    wire logic       bad_addr = paddr[1:0] != 2'h0 || !hit;
    wire logic [31:0] rd_mux  = cfg_hit ? {24'h0, cfg_ff[cfg_ch][cfg_sel]} :
                                st_hit  ? {30'h0, stat_ff} :
                                mk_hit  ? {30'h0, mask_ff} :
                                sm_hit  ? {20'h0, last_ff} : 32'h0;

    // No wait state: answer one cycle after setup, in the first access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && bad_addr;
            prdata_ff  <= (setup && !pwrite && !bad_addr) ? rd_mux : 32'h0;
        end
    end
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    wire logic cfg_wr = wr_do && cfg_hit && !bad_addr;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int c = 0; c < 2; c++) begin
                cfg_ff[c][0] <= `AWD_RST_HYS;
                cfg_ff[c][1] <= `AWD_RST_HIGH;
                cfg_ff[c][2] <= `AWD_RST_EVT;
                cfg_ff[c][3] <= `AWD_RST_LOW;
            end
        end else if (cfg_wr) begin
            cfg_ff[cfg_ch][cfg_sel] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Channel comparators
    // ------------------------------------------------------------
    awd_chan_if ch_if [2] ();
    logic [1:0] alert;
    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign ch_if[g].hys_reg  = cfg_ff[g][0];
        assign ch_if[g].high_reg = cfg_ff[g][1];
        assign ch_if[g].evt_reg  = cfg_ff[g][2];
        assign ch_if[g].low_reg  = cfg_ff[g][3];
        assign ch_if[g].smp_vld  = smp_vld && smp_chan == 3'(g + 2);
        assign ch_if[g].smp      = smp_data;
        assign alert[g]          = ch_if[g].alert;
        awd_chan_cmp u_cmp (
            .clk     (clk),
            .sys_rst (sys_rst),
            .ch      (ch_if[g])
        );
    end

    // ------------------------------------------------------------
    // Sticky status, mask, interrupt
    // ------------------------------------------------------------
    wire logic [1:0] st_clr = (wr_do && st_hit && !bad_addr) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_ff <= 2'h0;
            mask_ff <= 2'h0;
            irq_ff  <= 1'b0;
            last_ff <= 12'h000;
        end else begin
            stat_ff <= (stat_ff & ~st_clr) | alert;
            if (wr_do && mk_hit && !bad_addr)
                mask_ff <= pwdata[1:0];
            irq_ff  <= |(((stat_ff & ~st_clr) | alert) & mask_ff);
            if (smp_vld)
                last_ff <= smp_data;
        end
    end
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_values_a: assert property (@(posedge clk)
        $past(sys_rst) && !sys_rst |-> cfg_ff[0][0] == `AWD_RST_HYS
                           && cfg_ff[1][0] == `AWD_RST_HYS && cfg_ff[0][1] == `AWD_RST_HIGH
                           && cfg_ff[1][1] == `AWD_RST_HIGH && cfg_ff[0][2] == `AWD_RST_EVT
                           && cfg_ff[1][2] == `AWD_RST_EVT && cfg_ff[0][3] == `AWD_RST_LOW
                           && cfg_ff[1][3] == `AWD_RST_LOW)
        else $error("reset value wrong");
    c3_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_do && !bad_addr && idx == {2'h0, `AWD_IDX_C3_HIGH} |=> cfg_ff[1][1] == $past(pwdata[7:0]))
        else $error("channel 3 high byte not at its address");
    sticky_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        |alert |=> (stat_ff & $past(alert)) == $past(alert))
        else $error("alert lost");
endmodule : awd_wdw_top

//--- tb/awd_wdw_tb_top.sv
`timescale 1ns/1ps
module awd_wdw_tb_top;
    import awd_wdw_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq;
    logic        smp_vld = 1'b0;
    logic [2:0]  smp_chan = 3'h0;
    logic [11:0] smp_data = 12'h000;
    logic [31:0] rd_q;
    logic        rd_err;
    int          num_errors = 0;
    int          total_checks = 0;
    localparam logic [11:0] STAT = 12'h100, MASK = 12'h104;
    localparam logic [7:0] RST_TBL [8] = '{8'hF0, 8'hFF, 8'h00, 8'h00,
                                           8'hF0, 8'hFF, 8'h00, 8'h00};

    awd_wdw_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .smp_vld(smp_vld), .smp_chan(smp_chan),
        .smp_data(smp_data), .irq(irq));

    always #12.5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // --------------------------------------------
    // APB transfer, held until pready
    // --------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", rd_q, exp);
    endtask : rd

    task automatic smp(input logic [2:0] c, input logic [11:0] d);
        smp_vld <= 1'b1; smp_chan <= c; smp_data <= d;
        @(posedge clk);
        smp_vld <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : smp

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values of both channels' sets
        for (int i = 0; i < 8; i++) rd(12'h0A0 + 12'(i * 4), {24'h0, RST_TBL[i]});
        rd(MASK, 32'h0);
        $display("test reset done");
        // Readback, unmapped and unaligned refusal
        apb(1'b1, 12'h0B0, 32'h0000_00A5);
        rd(12'h0B0, 32'h0000_00A5);
        chk("mapped err", {31'h0, rd_err}, 32'h0);
        apb(1'b1, 12'h0BC, 32'hFFFF_FF3C);
        rd(12'h0BC, 32'h0000_003C);
        rd(12'h0FC, 32'h0);
        chk("unmapped err", {31'h0, rd_err}, 32'h1);
        rd(12'h0B1, 32'h0);
        chk("unaligned err", {31'h0, rd_err}, 32'h1);
        $display("test access done");
        // Ch3 high limit 0x805, three samples needed
        apb(1'b1, 12'h0B0, 32'h50);
        apb(1'b1, 12'h0B4, 32'h80);
        apb(1'b1, 12'h0B8, 32'h02);
        apb(1'b1, 12'h0BC, 32'h00);
        apb(1'b1, MASK, 32'h3);
        smp(3'd3, 12'h805);
        smp(3'd3, 12'h806);
        smp(3'd3, 12'h806);
        rd(STAT, 32'h0);
        smp(3'd5, 12'hFFF);
        rd(STAT, 32'h0);
        smp(3'd3, 12'h806);
        rd(STAT, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, STAT, 32'h2);
        rd(STAT, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        $display("test count done");
        // Hysteresis 8, return inside restarts the count
        apb(1'b1, 12'h0B0, 32'h51);
        smp(3'd3, 12'h7FD);
        smp(3'd3, 12'h806);
        smp(3'd3, 12'h806);
        smp(3'd3, 12'h7FD);
        smp(3'd3, 12'h806);
        smp(3'd3, 12'h806);
        rd(STAT, 32'h0);
        smp(3'd3, 12'h806);
        rd(STAT, 32'h2);
        apb(1'b1, STAT, 32'h2);
        $display("test restart done");
        // Ch2 low limit 0x403, one sample, then masked
        apb(1'b1, 12'h0A8, 32'h30);
        apb(1'b1, 12'h0AC, 32'h40);
        smp(3'd2, 12'h403);
        rd(STAT, 32'h0);
        smp(3'd2, 12'h402);
        rd(STAT, 32'h1);
        rd(12'h108, 32'h0000_0402);
        apb(1'b1, MASK, 32'h2);
        @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, STAT, 32'h1);
        rd(STAT, 32'h0);
        $display("test low done");
        complete_run();
    end
endmodule : awd_wdw_tb_top
